// ==== logic/dhwp_pkg.sv ====
// Purpose: shared constants and carrier types for the display host write port
// Assumes: clk_sys at 250 MHz
// Notes:   the strobe count derives from a named time; other counts are given directly
`default_nettype none
package dhwp_pkg;
  // -------------------------------------------------------------------------
  // widths and decode
  // -------------------------------------------------------------------------
  localparam int unsigned DATA_W        = 8;      // low half of host bus
  localparam int unsigned HBUS_W        = 16;     // full host data bus
  localparam int unsigned ADDR_W        = 3;      // decoder address inputs
  localparam logic [2:0]  ANN_CODE      = 3'h5;   // annunciator strobe output
  localparam logic [2:0]  DISP_CODE     = 3'h7;   // display write strobe output
  localparam int unsigned FIFO_DEPTH    = 16;     // command queue words
  localparam int unsigned RAM_BYTES     = 128;    // internal working ram
  localparam int unsigned TIMER_W       = 8;      // down counter width
  localparam int unsigned ALE_PRESCALE  = 32;     // timer prescale
  localparam int unsigned ALE_DIV       = 15;     // clocks per ale period
  localparam int unsigned PORT_W        = 8;      // parallel port width
  // -------------------------------------------------------------------------
  // timing
  // -------------------------------------------------------------------------
  localparam int unsigned CLK_PS        = 4000;   // clk_sys period, ps
  localparam int unsigned STROBE_NS     = 400;    // host strobe low time
  localparam int unsigned STROBE_CYC    = (STROBE_NS * 1000) / CLK_PS;
  localparam int unsigned XTAL_KHZ      = 10920;  // crystal rate
  localparam int unsigned REFRESH_CYC   = 64;     // refresh slot length
  localparam logic [7:0]  TIMER_RST     = 8'hff;  // timer reload value
  // -------------------------------------------------------------------------
  // carrier types
  // -------------------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;    // instrument address
    logic              sel_n;   // display select, low true
    logic [HBUS_W-1:0] data;    // instrument data bus
  } dhwp_host_t;
  typedef struct packed {
    logic              valid;   // command valid
    logic [DATA_W-1:0] byte_v;  // command byte
  } dhwp_cmd_t;
  typedef enum logic [1:0] {
    DHWP_IDLE  = 2'b00,         // no read under way; a request waits here on a full queue
    DHWP_READ  = 2'b01,         // read strobe low, moving latch
    DHWP_WAIT  = 2'b11          // read done, held until the host strobe is high
  } dhwp_svc_t;
endpackage : dhwp_pkg
`default_nettype wire

// ==== logic/dhwp_top.sv ====
// Purpose: host write port, service request latch and command queue of the display
// Assumes: host pins are asynchronous and pass two flip-flops
// Notes:   strictly host to display; nothing is returned to the host
`timescale 1ns/1ns
`default_nettype none

// ---------------------------------------------------------------------------
// command fifo
// ---------------------------------------------------------------------------
module dhwp_fifo #(
  parameter int unsigned WIDTH = 8,                      // word width
  parameter int unsigned DEPTH = 16                      // word count
) (
  input  wire logic             clk_sys,                 // system clock
  input  wire logic             rst_b,                   // async reset, low
  input  wire logic             ce,                      // clock enable
  input  wire logic             in_valid,                // write request
  output logic                  in_ready,                // room available
  input  wire logic [WIDTH-1:0] in_data,                 // write word
  output logic                  out_valid,               // word available
  input  wire logic             out_ready,               // reader takes word
  output logic [WIDTH-1:0]      out_data,                // head word
  output logic                  full,                    // queue full
  output logic                  empty                    // queue empty
);
  localparam int unsigned PW = $clog2(DEPTH);            // pointer width
  logic [WIDTH-1:0] mem [DEPTH];                         // storage
  logic [PW:0]      wr_r;                                // write pointer
  logic [PW:0]      rd_r;                                // read pointer
  wire              do_wr;                               // accepted write
  wire              do_rd;                               // accepted read

  // full when pointers differ only in wrap bit
  assign full      = (wr_r[PW] != rd_r[PW]) && (wr_r[PW-1:0] == rd_r[PW-1:0]);
  assign empty     = (wr_r == rd_r);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign do_wr     = ce && in_valid && !full;
  assign do_rd     = ce && out_ready && !empty;
  assign out_data  = mem[rd_r[PW-1:0]];

  // storage write
  always_ff @(posedge clk_sys)
  begin
    if (do_wr)
    begin
      mem[wr_r[PW-1:0]] <= in_data;
    end
  end

  // pointer update
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_r <= '0;
      rd_r <= '0;
    end
    else
    begin
      if (do_wr) wr_r <= wr_r + 1'b1;
      if (do_rd) rd_r <= rd_r + 1'b1;
    end
  end
endmodule : dhwp_fifo

// ---------------------------------------------------------------------------
// top
// ---------------------------------------------------------------------------
module dhwp_top
  import dhwp_pkg::*;
#(
  parameter int unsigned DEPTH = dhwp_pkg::FIFO_DEPTH    // command queue depth
) (
  input  wire logic                       clk_sys,       // system clock
  input  wire logic                       rst_b,         // async reset, low
  input  wire logic                       ce,            // clock enable
  input  wire dhwp_pkg::dhwp_host_t       host_in,       // host address, select, data
  input  wire logic                       sequence_clock,// display sequence clock
  output logic                            annunciator_strobe,   // decoded strobe, low
  output logic                            display_write_strobe, // decoded strobe, low
  output logic [dhwp_pkg::DATA_W-1:0]     ann_bits,      // annunciator latch
  output logic                            irq_n,         // service request, low
  output logic                            rd_n,          // processor read strobe
  output logic [dhwp_pkg::DATA_W-1:0]     disp_bus_o,    // internal display bus out
  output logic                            disp_bus_oe,   // display bus enable
  output logic                            addressable_latch_clock, // latch clock
  output dhwp_pkg::dhwp_cmd_t             cmd_out,       // executed command
  input  wire logic                       refresh_busy,  // refresh owns processor
  output logic [dhwp_pkg::TIMER_W-1:0]    timer_cnt,     // down counter value
  output logic                            ale,           // address latch enable
  input  wire logic [dhwp_pkg::PORT_W-1:0] port1_i,      // port 1 pins in
  output logic [dhwp_pkg::PORT_W-1:0]     port1_o,       // port 1 pins out
  output logic [dhwp_pkg::PORT_W-1:0]     port1_oe,      // port 1 enables
  input  wire logic [dhwp_pkg::PORT_W-1:0] port2_i,      // port 2 pins in
  output logic [dhwp_pkg::PORT_W-1:0]     port2_o,       // port 2 pins out
  output logic [dhwp_pkg::PORT_W-1:0]     port2_oe,      // port 2 enables
  input  wire logic [dhwp_pkg::PORT_W-1:0] port_dir,     // 1 = port bit output
  input  wire logic [dhwp_pkg::PORT_W-1:0] port1_wr,     // port 1 output data
  input  wire logic [dhwp_pkg::PORT_W-1:0] port2_wr,     // port 2 output data
  output logic [dhwp_pkg::PORT_W-1:0]     port1_rd,      // port 1 sampled
  output logic [dhwp_pkg::PORT_W-1:0]     port2_rd,      // port 2 sampled
  output logic                            fifo_full      // queue full, stalls service
);
  // -------------------------------------------------------------------------
  // pin synchronisers
  // -------------------------------------------------------------------------
  dhwp_host_t host_s1_r;                                 // first stage
  dhwp_host_t host_s2_r;                                 // second stage
  logic       seq_s1_r;                                  // sequence clock stage 1
  logic       seq_s2_r;                                  // sequence clock stage 2
  logic [PORT_W-1:0] p1_s1_r, p1_s2_r;                   // port 1 sync
  logic [PORT_W-1:0] p2_s1_r, p2_s2_r;                   // port 2 sync

  // two flip-flops ahead of all logic
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      host_s1_r <= '{addr: 3'h0, sel_n: 1'b1, data: 16'h0000};
      host_s2_r <= '{addr: 3'h0, sel_n: 1'b1, data: 16'h0000};
      seq_s1_r  <= 1'b0;
      seq_s2_r  <= 1'b0;
      p1_s1_r   <= '0;
      p1_s2_r   <= '0;
      p2_s1_r   <= '0;
      p2_s2_r   <= '0;
    end
    else
    begin
      host_s1_r <= host_in;
      host_s2_r <= host_s1_r;
      seq_s1_r  <= sequence_clock;
      seq_s2_r  <= seq_s1_r;
      p1_s1_r   <= port1_i;
      p1_s2_r   <= p1_s1_r;
      p2_s1_r   <= port2_i;
      p2_s2_r   <= p2_s1_r;
    end
  end

  // -------------------------------------------------------------------------
  // address decode
  // -------------------------------------------------------------------------
  wire ann_dec  = !host_s2_r.sel_n && (host_s2_r.addr == ANN_CODE);
  wire disp_dec = !host_s2_r.sel_n && (host_s2_r.addr == DISP_CODE);
  wire [DATA_W-1:0] host_byte = host_s2_r.data[DATA_W-1:0];
  logic ann_q_r;                                          // previous strobe
  logic disp_q_r;                                         // previous strobe
  logic [DATA_W-1:0] in_latch_r;                          // input latch
  logic [DATA_W-1:0] ann_r;                               // annunciator latch
  logic req_r;                                            // service request
  dhwp_svc_t svc_r, svc_nxt;                              // service state
  wire ann_rise  = ann_q_r && !ann_dec;                   // strobe returns high
  wire disp_fall = disp_dec && !disp_q_r;                 // strobe goes low
  wire fifo_ready;                                        // queue has room

  assign annunciator_strobe   = !ann_dec;
  assign display_write_strobe = !disp_dec;
  assign ann_bits             = ann_r;

  // strobe history, annunciator and input latches
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ann_q_r    <= 1'b0;
      disp_q_r   <= 1'b0;
      ann_r      <= '0;
      in_latch_r <= '0;
    end
    else if (ce)
    begin
      ann_q_r  <= ann_dec;
      disp_q_r <= disp_dec;
      if (ann_rise)
        ann_r <= host_byte;
      if (disp_dec)
        in_latch_r <= host_byte;
    end
  end

  // -------------------------------------------------------------------------
  // service request latch and read sequence
  // -------------------------------------------------------------------------
  wire rd_active = (svc_r == DHWP_READ);
  assign rd_n        = !rd_active;
  assign irq_n       = !req_r;
  assign disp_bus_oe = rd_active;
  assign disp_bus_o  = rd_active ? in_latch_r : '0;

  // service sequence: read only while the queue has room
  always_comb
  begin
    svc_nxt = svc_r;
    unique case (svc_r)
      DHWP_IDLE: if (req_r && fifo_ready) svc_nxt = DHWP_READ;
      DHWP_READ: svc_nxt = DHWP_WAIT;
      DHWP_WAIT: if (!disp_dec) svc_nxt = DHWP_IDLE;
      default:   svc_nxt = DHWP_IDLE;
    endcase
  end

  // request: set by strobe falling, cleared after the read once the strobe is high; set wins
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      req_r <= 1'b0;
      svc_r <= DHWP_IDLE;
    end
    else if (ce)
    begin
      svc_r <= svc_nxt;
      if (disp_fall)
        req_r <= 1'b1;
      else if ((rd_active || (svc_r == DHWP_WAIT)) && !disp_dec)
        req_r <= 1'b0;
    end
  end

  // -------------------------------------------------------------------------
  // command queue and execution
  // -------------------------------------------------------------------------
  wire              exec_ok = !refresh_busy;
  wire              q_valid;                              // queue not empty
  wire [DATA_W-1:0] q_data;                               // head byte
  dhwp_cmd_t        cmd_r;                                // executed command

  dhwp_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rst_b     (rst_b),
    .ce        (ce),
    .in_valid  (rd_active),
    .in_ready  (fifo_ready),
    .in_data   (in_latch_r),
    .out_valid (q_valid),
    .out_ready (exec_ok),
    .out_data  (q_data),
    .full      (fifo_full),
    .empty     ()
  );

  // execute head of queue in order
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      cmd_r <= '0;
    else if (ce)
    begin
      cmd_r.valid  <= q_valid && exec_ok;
      cmd_r.byte_v <= q_data;
    end
  end
  assign cmd_out = cmd_r;

  // -------------------------------------------------------------------------
  // working ram: registers, characters; queue lives alongside
  // -------------------------------------------------------------------------
  localparam int unsigned RAM_AW = $clog2(RAM_BYTES);
  logic [DATA_W-1:0] ram [RAM_BYTES];
  logic [RAM_AW-1:0] ram_ptr_r;                           // character slot

  // executed bytes stored as current characters
  always_ff @(posedge clk_sys)
  begin
    if (ce && cmd_r.valid)
      ram[ram_ptr_r] <= cmd_r.byte_v;
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      ram_ptr_r <= '0;
    else if (ce && cmd_r.valid)
      ram_ptr_r <= ram_ptr_r + 1'b1;
  end

  // -------------------------------------------------------------------------
  // ale, prescale and down counter
  // -------------------------------------------------------------------------
  logic [3:0] ale_div_r;                                  // ale divider
  logic [4:0] pre_r;                                      // ale/32 prescale
  logic [TIMER_W-1:0] tmr_r;                              // down counter
  wire ale_tick = (ale_div_r == 4'(ALE_DIV - 1));
  wire pre_tick = ale_tick && (pre_r == 5'(ALE_PRESCALE - 1));

  // processor timing base stands for the crystal oscillator
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ale_div_r <= '0;
      pre_r     <= '0;
      tmr_r     <= TIMER_RST;
    end
    else if (ce)
    begin
      ale_div_r <= ale_tick ? 4'h0 : ale_div_r + 1'b1;
      if (ale_tick)
        pre_r <= pre_r + 1'b1;
      if (pre_tick)
        tmr_r <= tmr_r - 1'b1;
    end
  end
  assign ale       = ale_tick;
  assign timer_cnt = tmr_r;

  // -------------------------------------------------------------------------
  // latch clock and parallel ports
  // -------------------------------------------------------------------------
  assign addressable_latch_clock = !(rst_b && seq_s2_r);
  assign port1_o  = port1_wr;
  assign port2_o  = port2_wr;
  assign port1_oe = port_dir;
  assign port2_oe = port_dir;

  // sampled port inputs
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      port1_rd <= '0;
      port2_rd <= '0;
    end
    else if (ce)
    begin
      port1_rd <= p1_s2_r;
      port2_rd <= p2_s2_r;
    end
  end
endmodule : dhwp_top
`default_nettype wire

// ==== sim/dhwp_host_model.sv ====
// Purpose: instrument host processor writing the display port
// Assumes: pins change at the falling clock edge
// Notes:   released lines show changed values, never the last ones
`timescale 1ns/1ns
`default_nettype none
module dhwp_host_model
  import dhwp_pkg::*;
(
  input  wire logic               clk_sys,  // clock
  output var dhwp_pkg::dhwp_host_t host_in  // host pins
);
  initial host_in = '{addr: 3'h0, sel_n: 1'b1, data: 16'h0000};
  // select a code, byte on low half, its complement on the unused upper half
  task automatic drive(input logic [2:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    host_in.addr = a;
    host_in.data = {~d, d};
    host_in.sel_n = 1'b0;
  endtask : drive
  // end the strobe, hold data a little, then the bus floats
  task automatic release_bus();
    @(negedge clk_sys);
    host_in.sel_n = 1'b1;
    repeat (6) @(negedge clk_sys);
    host_in.data = ~host_in.data;
    host_in.addr = ~host_in.addr;
  endtask : release_bus
  // whole write; extra cycles model a slow host
  task automatic write(input logic [2:0] a, input logic [7:0] d, input int extra);
    drive(a, d);
    repeat (STROBE_CYC + extra) @(negedge clk_sys);
    release_bus();
  endtask : write
endmodule : dhwp_host_model
`default_nettype wire

// ==== sim/dhwp_properties.sv ====
// Purpose: port-level checker bound to every dhwp_top
// Assumes: one clock domain, rst_b async low, two-flop host sync
// Notes:   latencies follow the hand-over walk of the write port
`timescale 1ns/1ns
`default_nettype none
module dhwp_properties
  import dhwp_pkg::*;
#(
  parameter int unsigned DEPTH = 16                        // queue depth
) (
  input wire logic                      clk_sys,              // clock
  input wire logic                      rst_b,                // reset, low
  input wire logic                      ce,                   // clock enable
  input wire dhwp_pkg::dhwp_host_t      host_in,              // host pins
  input wire logic                      sequence_clock,       // seq clock
  input wire logic                      annunciator_strobe,   // decoded, low
  input wire logic                      display_write_strobe, // decoded, low
  input wire logic [DATA_W-1:0]         ann_bits,             // annunciator latch
  input wire logic                      irq_n,                // request, low
  input wire logic                      rd_n,                 // read strobe
  input wire logic [DATA_W-1:0]         disp_bus_o,           // display bus
  input wire logic                      disp_bus_oe,          // bus enable
  input wire logic                      addressable_latch_clock, // latch clock
  input wire dhwp_pkg::dhwp_cmd_t       cmd_out,              // executed byte
  input wire logic                      refresh_busy,         // refresh active
  input wire logic [TIMER_W-1:0]        timer_cnt,            // down counter
  input wire logic                      fifo_full             // queue full
);
  // -------------------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // strobes only for their own code, two sync edges late
  a_disp_decode: assert property (!display_write_strobe |->
    $past(host_in.addr, 2) == DISP_CODE && !$past(host_in.sel_n, 2)) else $error("write strobe off code");
  a_ann_decode: assert property (!annunciator_strobe |->
    $past(host_in.addr, 2) == ANN_CODE && !$past(host_in.sel_n, 2)) else $error("ann strobe off code");
  // request set one cycle after the strobe falls
  a_irq_set: assert property ($fell(display_write_strobe) && ce |=> !irq_n)
    else $error("request not set");
  // request clears only with the host strobe high
  a_irq_clear: assert property ($rose(irq_n) |-> display_write_strobe)
    else $error("request cleared under strobe");
  a_read_pending: assert property (!rd_n |-> !irq_n)
    else $error("read without request");
  a_read_pulse: assert property ($fell(rd_n) |=> rd_n)
    else $error("read strobe too long");
  // latch reaches the display bus only during the read
  a_bus_gate: assert property ((disp_bus_oe != rd_n) && (!rd_n || disp_bus_o == 8'h00))
    else $error("display bus outside read");
  a_latch_clk: assert property ($rose(sequence_clock) ##1 sequence_clock [*2] |-> !addressable_latch_clock)
    else $error("latch clock not nand");
  a_ann_load: assert property ($rose(annunciator_strobe) |-> ##[0:2] ann_bits == host_in.data[DATA_W-1:0])
    else $error("annunciator bits not loaded");
  a_refresh_hold: assert property (refresh_busy [*4] |-> !cmd_out.valid)
    else $error("execute during refresh");
  a_timer_step: assert property (timer_cnt != $past(timer_cnt) |-> timer_cnt == $past(timer_cnt) - 8'h01)
    else $error("timer not counting down");
  a_full_stall: assert property (fifo_full |-> rd_n)
    else $error("read into full queue");
  // main scenarios reached
  c_service: cover property ($fell(rd_n));
  c_full: cover property ($rose(fifo_full));
  c_ann: cover property ($rose(annunciator_strobe));
endmodule : dhwp_properties

bind dhwp_top dhwp_properties #(.DEPTH(DEPTH)) u_props (
  .clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .host_in(host_in), .sequence_clock(sequence_clock),
  .annunciator_strobe(annunciator_strobe), .display_write_strobe(display_write_strobe),
  .ann_bits(ann_bits), .irq_n(irq_n), .rd_n(rd_n), .disp_bus_o(disp_bus_o), .disp_bus_oe(disp_bus_oe),
  .addressable_latch_clock(addressable_latch_clock), .cmd_out(cmd_out), .refresh_busy(refresh_busy),
  .timer_cnt(timer_cnt), .fifo_full(fifo_full));
`default_nettype wire

// ==== sim/dhwp_top_bench.sv ====
// Purpose: self-checking bench for the display host write port
// Assumes: host model drives the pins, bench the rest at negedge
// Notes:   the run ends through complete_run only
`timescale 1ns/1ns
`default_nettype none
module dhwp_top_bench;
  import dhwp_pkg::*;
  // -------------------------------------------------------------------------
  // signals
  // -------------------------------------------------------------------------
  logic             clk_sys = 1'b0;        // clock
  logic             rst_b = 1'b0;          // reset, low
  logic             ce = 1'b1;             // enable
  logic             sequence_clock = 1'b0; // seq clock
  logic             refresh_busy = 1'b0;   // refresh owns cpu
  logic [7:0]       port_dir = 8'h00, port1_wr = 8'h00, port2_wr = 8'h00, port1_i = 8'h00, port2_i = 8'h00;
  logic [7:0]       ann_bits, bus_o, timer, p1_o, p1_oe, p2_o, p2_oe, p1_rd, p2_rd, bus_seen;
  logic             ann_s, wr_s, irq_n, rd_n, bus_oe, lclk, ale, fifo_full;
  dhwp_host_t       host_in;               // host pins
  dhwp_cmd_t        cmd;                   // executed byte
  logic [7:0]       got[$];                // executed bytes in order
  int               error_cnt = 0;         // mismatches
  int               tests_run = 0;         // comparisons
  always #2 clk_sys = ~clk_sys;
  dhwp_host_model host (.clk_sys(clk_sys), .host_in(host_in));
  dhwp_top #(.DEPTH(FIFO_DEPTH)) dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .host_in(host_in), .sequence_clock(sequence_clock),
    .annunciator_strobe(ann_s), .display_write_strobe(wr_s), .ann_bits(ann_bits), .irq_n(irq_n),
    .rd_n(rd_n), .disp_bus_o(bus_o), .disp_bus_oe(bus_oe), .addressable_latch_clock(lclk),
    .cmd_out(cmd), .refresh_busy(refresh_busy), .timer_cnt(timer), .ale(ale), .port1_i(port1_i),
    .port1_o(p1_o), .port1_oe(p1_oe), .port2_i(port2_i), .port2_o(p2_o), .port2_oe(p2_oe),
    .port_dir(port_dir), .port1_wr(port1_wr), .port2_wr(port2_wr), .port1_rd(p1_rd), .port2_rd(p2_rd),
    .fifo_full(fifo_full));
  // mid-cycle monitor of read byte and executed bytes
  always @(negedge clk_sys)
  begin
    if (rd_n === 1'b0) bus_seen = bus_o;
    if (cmd.valid === 1'b1) got.push_back(cmd.byte_v);
  end
  // -------------------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // bounded wait on the request line
  task automatic wait_irq(input logic lvl);
    int n;
    for (n = 0; n < 200 && irq_n !== lvl; n++) @(negedge clk_sys);
    chk("irq_n wait", 8'(lvl), 8'(irq_n));
    if (irq_n !== lvl) complete_run();
  endtask : wait_irq
  // -------------------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------------------
  task automatic t_reset();
    repeat (3) @(negedge clk_sys);
    chk("irq_n", 8'h01, 8'(irq_n));
    chk("rd_n", 8'h01, 8'(rd_n));
    chk("latch clk", 8'h01, 8'(lclk));
    chk("bus_oe", 8'h00, 8'(bus_oe));
    chk("timer", TIMER_RST, timer);
    repeat (3) @(negedge clk_sys);
    rst_b = 1'b1;
  endtask : t_reset
  task automatic t_timer();
    int pulses;
    pulses = 0;
    repeat (ALE_PRESCALE * ALE_DIV)
    begin
      @(negedge clk_sys);
      if (ale === 1'b1) pulses++;
    end
    chk("ale count", 8'(ALE_PRESCALE), 8'(pulses));
    repeat (10) @(negedge clk_sys);
    chk("timer", TIMER_RST - 8'h01, timer);
  endtask : t_timer
  task automatic t_ports();
    port_dir = 8'h0f;
    port1_wr = 8'h3c;
    port2_wr = 8'hc3;
    port1_i = 8'ha1;
    port2_i = 8'h1a;
    repeat (4) @(negedge clk_sys);
    chk("port1_o", 8'h3c, p1_o);
    chk("port2_o", 8'hc3, p2_o);
    chk("port1_oe", 8'h0f, p1_oe);
    chk("port2_oe", 8'h0f, p2_oe);
    chk("port1_rd", 8'ha1, p1_rd);
    chk("port2_rd", 8'h1a, p2_rd);
  endtask : t_ports
  // every code but the write code: only code 5 strobes
  task automatic t_decode();
    for (int a = 0; a < 7; a++)
    begin
      host.drive(3'(a), 8'(8'h50 + a));
      repeat (4) @(negedge clk_sys);
      chk("ann strobe", 8'(a != 5), 8'(ann_s));
      chk("write strobe", 8'h01, 8'(wr_s));
      host.release_bus();
      chk("irq_n", 8'h01, 8'(irq_n));
    end
    chk("ann bits", 8'h55, ann_bits);
  endtask : t_decode
  // read happens under a held strobe, clear must wait
  task automatic t_service();
    got.delete();
    bus_seen = 8'h00;
    host.drive(DISP_CODE, 8'ha5);
    wait_irq(1'b0);
    repeat (STROBE_CYC) @(negedge clk_sys);
    chk("irq held", 8'h00, 8'(irq_n));
    chk("latch to bus", 8'ha5, bus_seen);
    host.release_bus();
    wait_irq(1'b1);
    chk("cmd count", 8'h01, 8'(got.size()));
    chk("cmd byte", 8'ha5, got[0]);
  endtask : t_service
  // fill past depth under refresh, then drain in order
  task automatic t_queue();
    refresh_busy = 1'b1;
    got.delete();
    for (int i = 0; i <= FIFO_DEPTH; i++)
      host.write(DISP_CODE, 8'(8'h10 + i), (i % 2) * 20);
    chk("fifo full", 8'h01, 8'(fifo_full));
    chk("irq stalled", 8'h00, 8'(irq_n));
    chk("held back", 8'h00, 8'(got.size()));
    refresh_busy = 1'b0;
    for (int n = 0; n < 400 && got.size() <= FIFO_DEPTH; n++) @(negedge clk_sys);
    chk("drained", 8'(FIFO_DEPTH + 1), 8'(got.size()));
    if (got.size() <= FIFO_DEPTH) complete_run();
    foreach (got[k]) chk("order", 8'(8'h10 + k), got[k]);
    wait_irq(1'b1);
  endtask : t_queue
  task automatic t_seq_reset();
    sequence_clock = 1'b1;
    repeat (4) @(negedge clk_sys);
    chk("latch clk low", 8'h00, 8'(lclk));
    sequence_clock = 1'b0;
    repeat (4) @(negedge clk_sys);
    chk("latch clk high", 8'h01, 8'(lclk));
    sequence_clock = 1'b1;
    repeat (4) @(negedge clk_sys);
    rst_b = 1'b0;
    #1;
    chk("latch clk reset", 8'h01, 8'(lclk));
    chk("irq reset", 8'h01, 8'(irq_n));
    repeat (6) @(negedge clk_sys);
    rst_b = 1'b1;
    repeat (4) @(negedge clk_sys);
    // write under a frozen enable, then serviced once enabled
    ce = 1'b0;
    host.drive(DISP_CODE, 8'h3e);
    repeat (8) @(negedge clk_sys);
    chk("irq frozen", 8'h01, 8'(irq_n));
    ce = 1'b1;
    wait_irq(1'b0);
    host.release_bus();
    wait_irq(1'b1);
    chk("cmd after reset", 8'h3e, got[$]);
  endtask : t_seq_reset
  initial
  begin
    t_reset();
    t_timer();
    t_ports();
    t_decode();
    t_service();
    t_queue();
    t_seq_reset();
    complete_run();
  end
endmodule : dhwp_top_bench
`default_nettype wire
